// File: rtl/fapb_pkg.sv
`default_nettype none
package fapb_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register offsets
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h500;
  localparam logic [ADDR_W-1:0] WO_OFFSET     = 12'h504;
  localparam logic [ADDR_W-1:0] W1_OFFSET     = 12'h508;
  localparam logic [ADDR_W-1:0] RW1_OFFSET    = 12'h50c;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 12'h514;

  // Reset values and masks
  localparam logic [DATA_W-1:0] CTRL_RESET      = 32'h0005_0002;
  localparam logic [DATA_W-1:0] CTRL_FIELD_MASK = 32'hf007_0103;
  localparam logic [DATA_W-1:0] WO_RESET        = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ONCE_RESET      = 32'h0000_0000;
  // Value driven where a read is undefined or unmapped
  localparam logic [DATA_W-1:0] UNDEF_READ      = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_OFF      = 2'b00,
    MODE_NORMAL   = 2'b01,
    MODE_EXTENDED = 2'b10,
    MODE_UNDEF    = 2'b11
  } fapb_mode_e;

  // Example feature control register layout
  typedef struct packed {
    logic [3:0] free;
    logic [8:0] rsv_hi;
    logic [2:0] range;
    logic [6:0] rsv_mid;
    logic       override;
    logic [5:0] rsv_lo;
    fapb_mode_e mode;
  } fapb_ctrl_s;

  // Read-only status register layout
  typedef struct packed {
    logic [27:0] rsv;
    fapb_mode_e  mode;
    logic        rw1_locked;
    logic        w1_locked;
  } fapb_status_s;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } fapb_req_s;

endpackage
`default_nettype wire

// File: rtl/fapb_once_field.sv
`timescale 1ns/100ps
`default_nettype none

module fapb_once_field
  import fapb_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wdata,
  output var  logic [DATA_W-1:0] value,
  output var  logic              locked
);

  logic [DATA_W-1:0] next_value;
  logic              next_locked;

  // Lock only clears on reset; no software path can reopen the field
  always_comb
  begin
    next_value  = value;
    next_locked = locked;
    if (wr_en && !locked) // [RULE_04] [RULE_05]
    begin
      next_value  = wdata;
      next_locked = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      value  <= ONCE_RESET;
      locked <= 1'b0;
    end
    else
    begin
      value  <= next_value;
      locked <= next_locked;
    end
  end

  first_store_a: assert property (@(posedge clk) disable iff (rst) // [RULE_05]
    wr_en && !locked |=> locked && value == $past(wdata))
    else $error("once field missed its first write");

  later_ignored_a: assert property (@(posedge clk) disable iff (rst) // [RULE_05]
    locked |=> locked && $stable(value))
    else $error("once field changed after lock");

endmodule

`default_nettype wire

// File: rtl/fapb_bank.sv
// What this block does
// [RULE_01] Read-only field: readable, writes ignored
// [RULE_02] Write-only field: stores writes, reads undefined
// [RULE_03] Read-write field: returns last written value
// [RULE_04] Write-once field: first write kept, reads undefined
// [RULE_05] Read-write-once: first write kept, always readable
// [RULE_06] Reserved bits read undefined, software writes zero
// [RULE_07] Control register at 0x514, reset 0x00050002
// [RULE_08] Mode: off, normal, extended operation
// [RULE_09] Deprecated override flag: 0 off, 1 on
// [RULE_10] Software keeps range field within permitted values
// [RULE_11] Free field holds any written value
// [RULE_12] Field placement reproduces the reset image
`timescale 1ns/100ps
`default_nettype none

module fapb_bank
  import fapb_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire fapb_req_s         req,
  output var  logic [DATA_W-1:0] rdata,
  output var  fapb_ctrl_s        ctrl,
  output var  logic              feature_on,
  output var  logic              normal_operation,
  output var  logic              extended_operation,
  output var  logic              override_on,
  output var  logic [DATA_W-1:0] wo_value,
  output var  logic [DATA_W-1:0] write_once_access,
  output var  logic [DATA_W-1:0] read_write_once_access
);

  import fapb_pkg::*;

  fapb_ctrl_s        next_ctrl;
  logic              next_feature_on;
  logic              next_normal_operation;
  logic              next_extended_operation;
  logic              next_override_on;
  logic [DATA_W-1:0] next_wo_value;
  logic [DATA_W-1:0] next_rdata;
  logic              w1_locked;
  logic              rw1_locked;
  logic              wr_ctrl;
  logic              wr_wo;
  logic              wr_w1;
  logic              wr_rw1;
  fapb_status_s      status;
  fapb_ctrl_s        wr_view;

  assign wr_ctrl = req.wr && (req.addr == CTRL_OFFSET);
  assign wr_wo   = req.wr && (req.addr == WO_OFFSET);
  assign wr_w1   = req.wr && (req.addr == W1_OFFSET);
  assign wr_rw1  = req.wr && (req.addr == RW1_OFFSET);
  // Field view of the write word, so checks never name bit positions
  assign wr_view = fapb_ctrl_s'(req.wdata);

  // Status is built from live state; there is no storage to write
  always_comb
  begin
    status            = '0;
    status.mode       = ctrl.mode;
    status.w1_locked  = w1_locked;
    status.rw1_locked = rw1_locked;
  end

  fapb_once_field u_write_once
  (
    .clk    (clk),
    .rst    (rst),
    .wr_en  (wr_w1),
    .wdata  (req.wdata),
    .value  (write_once_access),
    .locked (w1_locked)
  );

  fapb_once_field u_read_write_once
  (
    .clk    (clk),
    .rst    (rst),
    .wr_en  (wr_rw1),
    .wdata  (req.wdata),
    .value  (read_write_once_access),
    .locked (rw1_locked)
  );

  // Control register and its decoded outputs
  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_ctrl)
    begin
      // Reserved bits are dropped so they always read back as zero
      next_ctrl = fapb_ctrl_s'(req.wdata & CTRL_FIELD_MASK); // [RULE_03] [RULE_06] [RULE_11]
    end
    // Range field is stored as written; out-of-range values stay the writer's problem
    next_feature_on         = (next_ctrl.mode == MODE_NORMAL) ||
                              (next_ctrl.mode == MODE_EXTENDED); // [RULE_08]
    next_normal_operation   = (next_ctrl.mode == MODE_NORMAL); // [RULE_08]
    next_extended_operation = (next_ctrl.mode == MODE_EXTENDED); // [RULE_08]
    next_override_on        = next_ctrl.override; // [RULE_09]
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl               <= fapb_ctrl_s'(CTRL_RESET); // [RULE_07] [RULE_12]
      feature_on         <= 1'b1;
      normal_operation   <= 1'b0;
      extended_operation <= 1'b1;
      override_on        <= 1'b0;
    end
    else
    begin
      ctrl               <= next_ctrl;
      feature_on         <= next_feature_on;
      normal_operation   <= next_normal_operation;
      extended_operation <= next_extended_operation;
      override_on        <= next_override_on;
    end
  end

  // Write-only register
  always_comb
  begin
    next_wo_value = wo_value;
    if (wr_wo)
    begin
      next_wo_value = req.wdata; // [RULE_02]
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wo_value <= WO_RESET;
    end
    else
    begin
      wo_value <= next_wo_value;
    end
  end

  // Read path; undefined and unmapped reads return a fixed value
  always_comb
  begin
    next_rdata = UNDEF_READ;
    if (req.rd)
    begin
      unique case (req.addr)
        CTRL_OFFSET:   next_rdata = ctrl; // [RULE_03]
        STATUS_OFFSET: next_rdata = status; // [RULE_01]
        WO_OFFSET:     next_rdata = UNDEF_READ; // [RULE_02]
        W1_OFFSET:     next_rdata = UNDEF_READ; // [RULE_04]
        RW1_OFFSET:    next_rdata = read_write_once_access; // [RULE_05]
        default:       next_rdata = UNDEF_READ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata <= UNDEF_READ;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ctrl_reset_a: assert property ($past(rst) |-> ctrl == fapb_ctrl_s'(CTRL_RESET)) // [RULE_07]
    else $error("control register reset value wrong");

  ro_status_a: assert property ( // [RULE_01]
    req.wr && req.addr == STATUS_OFFSET |=> $stable(ctrl) && $stable(wo_value)
      && $stable(write_once_access) && $stable(read_write_once_access))
    else $error("write to read-only status changed state");

  status_read_a: assert property ( // [RULE_01]
    req.rd && req.addr == STATUS_OFFSET |=> rdata == $past(status))
    else $error("status read value wrong");

  wo_store_a: assert property (wr_wo |=> wo_value == $past(req.wdata)) // [RULE_02]
    else $error("write-only register did not store");

  wo_read_a: assert property ( // [RULE_02]
    req.rd && (req.addr == WO_OFFSET || req.addr == W1_OFFSET) |=> rdata == UNDEF_READ)
    else $error("write-only read leaked data");

  rw_readback_a: assert property (wr_ctrl ##1 req.rd && req.addr == CTRL_OFFSET // [RULE_03]
    |=> rdata == ($past(req.wdata, 2) & CTRL_FIELD_MASK))
    else $error("control readback differs from last write");

  w1_lock_a: assert property (w1_locked && wr_w1 |=> $stable(write_once_access)) // [RULE_04]
    else $error("write-once field accepted second write");

  rw1_read_a: assert property ( // [RULE_05]
    req.rd && req.addr == RW1_OFFSET |=> rdata == $past(read_write_once_access))
    else $error("read-write-once read value wrong");

  reserved_zero_a: assert property (wr_ctrl |=> (ctrl & ~CTRL_FIELD_MASK) == '0) // [RULE_06]
    else $error("reserved control bits stored");

  mode_decode_a: assert property ( // [RULE_08]
    wr_ctrl |=> extended_operation == ($past(wr_view.mode) == MODE_EXTENDED)
      && normal_operation == ($past(wr_view.mode) == MODE_NORMAL))
    else $error("mode decode wrong");

  override_a: assert property (override_on == ctrl.override) // [RULE_09]
    else $error("override output disagrees with flag");

  free_hold_a: assert property ( // [RULE_11]
    wr_ctrl |=> ctrl.free == $past(wr_view.free))
    else $error("free field filtered a value");

  ctrl_hold_a: assert property (!wr_ctrl |=> $stable(ctrl)) // [RULE_03]
    else $error("control register changed without a write");

  w1_first_a: assert property ( // [RULE_04]
    wr_w1 && !w1_locked |=> w1_locked && write_once_access == $past(req.wdata))
    else $error("write-once field missed its first write");

  rw1_lock_a: assert property ( // [RULE_05]
    rw1_locked && wr_rw1 |=> $stable(read_write_once_access))
    else $error("read-write-once field accepted second write");

endmodule

`default_nettype wire

// File: verification/tb_fapb_bank.sv
`timescale 1ns/100ps
`default_nettype none
module tb_fapb_bank
  import fapb_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  fapb_req_s         req = '0;
  logic [DATA_W-1:0] rdata;
  fapb_ctrl_s        ctrl;
  logic              feature_on;
  logic              normal_operation;
  logic              extended_operation;
  logic              override_on;
  logic [DATA_W-1:0] wo_value;
  logic [DATA_W-1:0] write_once_access;
  logic [DATA_W-1:0] read_write_once_access;
  logic [31:0]       lf = 32'h0000_0060;
  logic [31:0]       exp_ctrl;
  logic [31:0]       a;
  logic [31:0]       b;
  logic              w1_lk;
  logic              rw1_lk;
  int                err_count = 0;
  int                samples_checked = 0;

  always #50 clk = ~clk;

  fapb_bank dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .ctrl(ctrl),
    .feature_on(feature_on), .normal_operation(normal_operation),
    .extended_operation(extended_operation), .override_on(override_on),
    .wo_value(wo_value), .write_once_access(write_once_access),
    .read_write_once_access(read_write_once_access));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] status_exp();
    return {28'h0, exp_ctrl[1:0], rw1_lk, w1_lk};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Each access leaves one idle cycle so no strobe is driven twice in a time step
  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
    @(posedge clk);
    req.addr  <= ad;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] want);
    @(posedge clk);
    req.addr <= ad;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk(rdata, want);
  endtask

  // Write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d,
                       input logic [DATA_W-1:0] want);
    @(posedge clk);
    req.addr  <= ad;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk(rdata, want);
  endtask

  // Reset is raised on an edge and held for two sampled edges
  task automatic do_reset();
    if (rst == 1'b0)
    begin
      @(posedge clk);
      rst <= 1'b1;
    end
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    w1_lk    = 1'b0;
    rw1_lk   = 1'b0;
    exp_ctrl = CTRL_RESET;
  endtask

  initial
  begin
    #(100 * 5000);
    err_count++;
    close_out();
  end

  initial
  begin
    do_reset();
    chk(ctrl, CTRL_RESET);
    chk({28'h0, feature_on, normal_operation, extended_operation, override_on},
        32'ha);
    rd_chk(CTRL_OFFSET, CTRL_RESET);
    @(posedge clk);
    #1;
    chk(rdata, UNDEF_READ);
    // Every mode code, override toggled alongside
    for (int m = 0; m < 4; m++)
    begin
      exp_ctrl = (CTRL_RESET & ~32'h0000_0103) | m | ((m % 2) << 8);
      wr(CTRL_OFFSET, exp_ctrl);
      chk({feature_on, normal_operation, extended_operation, override_on},
          {m == 1 || m == 2, m == 1, m == 2, m % 2 == 1});
    end
    // Corner values first, then random words with reserved bits kept zero
    for (int i = 0; i < 14; i++)
    begin
      lf = lfsr_next(lf);
      exp_ctrl = (i == 0) ? CTRL_FIELD_MASK : (i == 1) ? 32'h0 :
                 lf & CTRL_FIELD_MASK;
      // Odd passes read straight after the write, with no idle cycle
      if (i % 2 == 1)
      begin
        wr_rd(CTRL_OFFSET, exp_ctrl, exp_ctrl);
      end
      else
      begin
        wr(CTRL_OFFSET, exp_ctrl);
        rd_chk(CTRL_OFFSET, exp_ctrl);
      end
      chk(ctrl, exp_ctrl);
    end
    wr(STATUS_OFFSET, 32'hffff_ffff);
    rd_chk(STATUS_OFFSET, status_exp());
    repeat (2)
    begin
      lf = lfsr_next(lf);
      wr(WO_OFFSET, lf);
      chk(wo_value, lf);
      rd_chk(WO_OFFSET, UNDEF_READ);
    end
    // Second pass locks the write-once field with a value equal to the reset image
    for (int r = 0; r < 2; r++)
    begin
      lf = lfsr_next(lf);
      a = (r == 0) ? lf : ONCE_RESET;
      b = ~lf;
      wr(W1_OFFSET, a);
      wr(W1_OFFSET, b);
      chk(write_once_access, a);
      rd_chk(W1_OFFSET, UNDEF_READ);
      wr(RW1_OFFSET, b);
      wr(RW1_OFFSET, a);
      rd_chk(RW1_OFFSET, b);
      chk(read_write_once_access, b);
      w1_lk  = 1'b1;
      rw1_lk = 1'b1;
      rd_chk(STATUS_OFFSET, status_exp());
      do_reset();
      chk(write_once_access, ONCE_RESET);
      chk(read_write_once_access, ONCE_RESET);
      chk(ctrl, CTRL_RESET);
    end
    wr(12'h600, 32'hffff_ffff);
    chk(ctrl, CTRL_RESET);
    rd_chk(12'h600, UNDEF_READ);
    close_out();
  end
endmodule
`default_nettype wire
